// file: design/bbr_bitlane.sv
// Bit lane helper: extracts and replaces one bit of a byte within a little-endian word.
// Assumes band_addr low bits select the byte lane; purely combinational.
`default_nettype none

module bbr_bitlane (
	input  wire logic [31:0] word_in,
	input  wire logic [1:0]  lane,
	input  wire logic [2:0]  bit_num,
	input  wire logic        new_bit,
	output logic             cur_bit,
	output logic [31:0]      word_out
);

	// ==========================================================
	// Lane select, lowest address in the lowest byte
	wire [4:0] pos = {lane, bit_num};

	genvar g;
	generate
		for (g = 0; g < 32; g++) begin : g_bit
			assign word_out[g] = (pos == 5'(g)) ? new_bit : word_in[g];
		end
	endgenerate

	assign cur_bit = word_in[pos];

endmodule // bbr_bitlane

`default_nettype wire

// file: design/bbr_decode.sv
// Address decoder: classifies an upstream access and computes the bit-band target.
// Assumes a request carrier from the same clock domain; purely combinational.
`default_nettype none

module bbr_decode (
	input  wire logic [31:0] addr,
	input  wire logic        fetch,
	output logic             is_alias,
	output logic             refuse,
	output logic [31:0]      band_addr,
	output logic [2:0]       bit_num
);

	// ==========================================================
	// Window hits
	wire         hit_sram   = (addr >= bbr_pkg::SRAM_ALIAS_BASE) &&
	                          (addr <= bbr_pkg::SRAM_ALIAS_LAST);
	wire         hit_peri   = (addr >= bbr_pkg::PERI_ALIAS_BASE) &&
	                          (addr <= bbr_pkg::PERI_ALIAS_LAST);
	wire  [31:0] alias_off  = addr - (hit_sram ? bbr_pkg::SRAM_ALIAS_BASE
	                                           : bbr_pkg::PERI_ALIAS_BASE);
	wire  [31:0] byte_off   = (alias_off >> bbr_pkg::ALIAS_BYTE_SHIFT) &
	                          bbr_pkg::BAND_SPAN_MASK;
	wire  [31:0] band_base  = hit_sram ? bbr_pkg::SRAM_BAND_BASE
	                                   : bbr_pkg::PERI_BAND_BASE;

	// Fetches from the SRAM alias pass through untouched
	assign is_alias  = (hit_sram && !fetch) || (hit_peri && !fetch);
	assign refuse    = hit_peri && fetch;
	assign band_addr = band_base | byte_off;
	assign bit_num   = alias_off[bbr_pkg::ALIAS_BIT_LSB +: 3];

endmodule // bbr_decode

`default_nettype wire

// file: design/bbr_pkg.sv
// Package for the bit-band alias remapper: address windows, sizes, carriers.
// Assumes a single clock domain shared by the upstream master and downstream target.
`default_nettype none

package bbr_pkg;

	// ==========================================================
	// Address windows
	localparam logic [31:0] SRAM_BAND_BASE   = 32'h2000_0000;
	localparam logic [31:0] SRAM_ALIAS_BASE  = 32'h2200_0000;
	localparam logic [31:0] SRAM_ALIAS_LAST  = 32'h2207_FFFF;
	localparam logic [31:0] PERI_BAND_BASE   = 32'h4000_0000;
	localparam logic [31:0] PERI_ALIAS_BASE  = 32'h4200_0000;
	localparam logic [31:0] PERI_ALIAS_LAST  = 32'h43FF_FFFF;
	localparam logic [31:0] BAND_SPAN_MASK   = 32'h000F_FFFF;
	localparam int          ALIAS_BYTE_SHIFT = 5;
	localparam int          ALIAS_BIT_LSB    = 2;

	// ==========================================================
	// Access sizes
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_HALF = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;

	localparam logic [31:0] ALIAS_READ_ONE  = 32'h0000_0001;
	localparam logic [31:0] ALIAS_READ_ZERO = 32'h0000_0000;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic        valid;
		logic        write;
		logic        fetch;
		logic [1:0]  size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} bbr_req_t;

	typedef struct packed {
		logic        valid;
		logic        error;
		logic [31:0] rdata;
	} bbr_rsp_t;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic        lock;
		logic [1:0]  size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} bbr_mreq_t;

	typedef enum logic [2:0] {
		BBR_IDLE  = 3'b000,
		BBR_PASS  = 3'b001,
		BBR_RD    = 3'b010,
		BBR_WB    = 3'b011,
		BBR_DONE  = 3'b100
	} bbr_state_t;

endpackage : bbr_pkg

`default_nettype wire

// file: design/bbr_remap.sv
// Bit-band alias remapper: sits between the processor data bus and the memory targets.
// Assumes one-outstanding request handshake; downstream answers with a one-cycle valid.
`default_nettype none

module bbr_remap (
	input  wire logic              clk_sys,
	input  wire logic              rst,
	input  wire bbr_pkg::bbr_req_t up_req,
	output logic                   up_ready,
	output bbr_pkg::bbr_rsp_t      up_rsp,
	output bbr_pkg::bbr_mreq_t     dn_req,
	input  wire logic              dn_ready,
	input  wire bbr_pkg::bbr_rsp_t dn_rsp
);

	// ==========================================================
	// State
	bbr_pkg::bbr_state_t state;
	bbr_pkg::bbr_state_t next_state;
	bbr_pkg::bbr_req_t   held;
	logic [31:0]         held_band;
	logic [2:0]          held_bit;
	logic                held_alias;

	// ==========================================================
	// Decode of incoming request
	logic        dec_alias;
	logic        dec_refuse;
	logic [31:0] dec_band;
	logic [2:0]  dec_bit;

	bbr_decode u_decode (
		.addr      (up_req.addr),
		.fetch     (up_req.fetch),
		.is_alias  (dec_alias),
		.refuse    (dec_refuse),
		.band_addr (dec_band),
		.bit_num   (dec_bit)
	);

	// ==========================================================
	// Bit lane on the read data
	logic        cur_bit;
	logic [31:0] merged;

	bbr_bitlane u_lane (
		.word_in  (dn_rsp.rdata),
		.lane     (held_band[1:0]),
		.bit_num  (held_bit),
		.new_bit  (held.wdata[0]),
		.cur_bit  (cur_bit),
		.word_out (merged)
	);

	// ==========================================================
	// Handshake terms
	wire take      = up_req.valid && up_ready;
	wire dn_acc    = dn_req.valid && dn_ready;
	wire dn_done   = dn_rsp.valid;

	// Read data of an alias read is the target bit only
	wire [31:0] alias_rdata = cur_bit ? bbr_pkg::ALIAS_READ_ONE
	                                  : bbr_pkg::ALIAS_READ_ZERO;

	// ==========================================================
	// Next state
	always_comb begin
		next_state = state;
		case (state)
			bbr_pkg::BBR_IDLE: begin
				if (take && !dec_refuse) begin
					next_state = (dec_alias && up_req.write) ? bbr_pkg::BBR_RD
					                                         : bbr_pkg::BBR_PASS;
				end
			end
			bbr_pkg::BBR_PASS: begin
				if (dn_done) begin
					next_state = bbr_pkg::BBR_IDLE;
				end
			end
			bbr_pkg::BBR_RD: begin
				if (dn_done) begin
					next_state = bbr_pkg::BBR_WB;
				end
			end
			bbr_pkg::BBR_WB: begin
				if (dn_done) begin
					next_state = bbr_pkg::BBR_IDLE;
				end
			end
			default: begin
				next_state = bbr_pkg::BBR_IDLE;
			end
		endcase
	end

	// ==========================================================
	// Request capture
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state      <= bbr_pkg::BBR_IDLE;
			held       <= '0;
			held_band  <= 32'h0000_0000;
			held_bit   <= 3'h0;
			held_alias <= 1'b0;
		end else begin
			state <= next_state;
			if (take) begin
				held       <= up_req;
				held_band  <= dec_band;
				held_bit   <= dec_bit;
				held_alias <= dec_alias;
			end
		end
	end

	// ==========================================================
	// Upstream ready: only one access in flight
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			up_ready <= 1'b0;
		end else begin
			up_ready <= (next_state == bbr_pkg::BBR_IDLE) && !take;
		end
	end

	// ==========================================================
	// Downstream request
	// Lock covers both halves so no other master slips between them
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			dn_req <= '0;
		end else if (take && !dec_refuse) begin
			dn_req.valid <= 1'b1;
			dn_req.write <= up_req.write && !dec_alias;
			dn_req.lock  <= dec_alias && up_req.write;
			dn_req.size  <= up_req.size;
			dn_req.addr  <= dec_alias ? dec_band : up_req.addr;
			dn_req.wdata <= up_req.wdata;
		end else if (state == bbr_pkg::BBR_RD && dn_done) begin
			dn_req.valid <= 1'b1;
			dn_req.write <= 1'b1;
			dn_req.lock  <= 1'b1;
			dn_req.wdata <= merged;
		end else if (dn_acc) begin
			dn_req.valid <= 1'b0;
		end else if (state == bbr_pkg::BBR_WB && dn_done) begin
			dn_req.lock <= 1'b0;
		end
	end

	// ==========================================================
	// Upstream response
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			up_rsp <= '0;
		end else begin
			up_rsp.valid <= 1'b0;
			up_rsp.error <= 1'b0;
			if (take && dec_refuse) begin
				up_rsp.valid <= 1'b1;
				up_rsp.error <= 1'b1;
				up_rsp.rdata <= 32'h0000_0000;
			end else if (state == bbr_pkg::BBR_PASS && dn_done) begin
				up_rsp.valid <= 1'b1;
				up_rsp.error <= dn_rsp.error;
				up_rsp.rdata <= held_alias ? alias_rdata : dn_rsp.rdata;
			end else if (state == bbr_pkg::BBR_RD && dn_done && dn_rsp.error) begin
				up_rsp.rdata <= 32'h0000_0000;
			end else if (state == bbr_pkg::BBR_WB && dn_done) begin
				up_rsp.valid <= 1'b1;
				up_rsp.error <= dn_rsp.error;
				up_rsp.rdata <= 32'h0000_0000;
			end
		end
	end

endmodule // bbr_remap

`default_nettype wire

// file: verification/bbr_chk.sv
// Checker: port-level assertions for the remapper.
// Assumes one clock; bound to every bbr_remap instance.
`default_nettype none
module bbr_chk (
	input wire logic               clk_sys,
	input wire logic               rst,
	input wire bbr_pkg::bbr_req_t  up_req,
	input wire logic               up_ready,
	input wire bbr_pkg::bbr_rsp_t  up_rsp,
	input wire bbr_pkg::bbr_mreq_t dn_req,
	input wire logic               dn_ready,
	input wire bbr_pkg::bbr_rsp_t  dn_rsp
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// ==========
	// Capture of the taken request
	wire logic take = up_req.valid && up_ready;
	wire logic pa   = up_req.addr[31:25] == 7'h21;
	wire logic al   = (up_req.addr[31:19] == 13'h440 || pa) && !up_req.fetch;
	logic [31:0] ca, cw, rd;
	logic [1:0]  cs;
	logic        cr, cwr, cp;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			{ca, cw, rd, cs, cr, cwr, cp} <= '0;
		end else begin
			if (dn_rsp.valid) rd <= dn_rsp.rdata;
			if (take) begin
				{ca, cw, cs} <= {up_req.addr, up_req.wdata, up_req.size};
				cr <= al && !up_req.write;
				cwr <= al && up_req.write;
				cp <= !al && !(pa && up_req.fetch);
			end
		end
	end
	wire logic [31:0] ba = (ca[30] ? 32'h4000_0000 : 32'h2000_0000) | {12'h000, ca[24:5]};
	wire logic [31:0] bm = 32'h0000_0001 << ca[6:2];
	// ==========
	// Assertions
	sequence s_lrd;
		dn_req.valid && !dn_req.write && dn_req.lock;
	endsequence
	AST_RMW_RD: assert property (take && al && up_req.write |=> s_lrd)
		else $error("alias write lacks locked read");
	AST_RMW_WB: assert property (dn_req.valid && dn_req.write && cwr |-> dn_req.lock
		&& (dn_req.wdata | bm) == (rd | bm) && dn_req.wdata[ca[6:2]] == cw[0])
		else $error("bad write-back word");
	AST_MAP: assert property (dn_req.valid && (cr || cwr) |-> dn_req.addr == ba
		&& dn_req.size == cs) else $error("bad band address or size");
	AST_PASS: assert property (dn_req.valid && cp |-> dn_req.addr == ca && dn_req.size == cs
		&& (!dn_req.write || dn_req.wdata == cw)) else $error("direct access altered");
	AST_PASS_RSP: assert property (dn_rsp.valid && cp |=> up_rsp.valid && up_rsp.rdata == rd)
		else $error("direct read data altered");
	AST_RD_BIT: assert property (up_rsp.valid && cr |-> up_rsp.rdata == {31'h0, rd[ca[6:2]]})
		else $error("bad alias read value");
	AST_FETCH: assert property (take && pa && up_req.fetch |=> up_rsp.valid && up_rsp.error
		&& up_rsp.rdata == 32'h0 && !dn_req.valid) else $error("alias fetch not refused");
	AST_BUSY: assert property (take |=> !up_ready)
		else $error("accepted while busy");
endmodule // bbr_chk
bind bbr_remap bbr_chk bbr_chk_inst (.clk_sys, .rst, .up_req, .up_ready, .up_rsp,
	.dn_req, .dn_ready, .dn_rsp);
`default_nettype wire

// file: verification/bbr_mem.sv
// Target model: small word memory on the downstream side of the remapper.
// Assumes lane-aligned write data; 16 words, aliased by addr[5:2].
`default_nettype none
module bbr_mem (
	input  wire logic               clk_sys,
	input  wire logic               rst,
	input  wire logic               slow,
	input  wire bbr_pkg::bbr_mreq_t dn_req,
	output logic                    dn_ready,
	output bbr_pkg::bbr_rsp_t       dn_rsp
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========
	// Storage and lane merge
	logic [31:0] mem [16];
	logic [31:0] m;
	logic [31:0] w;
	logic        tick;
	// Slow mode accepts every other cycle to stretch the handshake
	assign dn_ready = dn_req.valid && (!slow || tick);
	assign m = mem[dn_req.addr[5:2]];
	always_comb begin
		w = m;
		for (int i = 0; i < 4; i++) begin
			if (dn_req.size == 2'h2 || (dn_req.size == 2'h1 && i / 2 == dn_req.addr[1])
					|| i == dn_req.addr[1:0]) begin
				w[i*8+:8] = dn_req.wdata[i*8+:8];
			end
		end
	end
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tick <= 1'h0;
			dn_rsp <= '0;
			// Cleared so an unknown word never reaches a compare or an assertion
			for (int i = 0; i < 16; i++) begin
				mem[i] <= 32'h0000_0000;
			end
		end else begin
			tick <= !tick;
			dn_rsp.valid <= dn_ready;
			dn_rsp.error <= 1'h0;
			// Idle data flips so a stale value is never mistaken for an answer
			dn_rsp.rdata <= dn_ready ? m : ~dn_rsp.rdata;
			if (dn_ready && dn_req.write) begin
				mem[dn_req.addr[5:2]] <= w;
			end
		end
	end
endmodule // bbr_mem
`default_nettype wire

// file: verification/tb_bbr_remap.sv
// Testbench: direct, alias and fetch accesses through the remapper.
// Assumes bbr_mem on the target side and bbr_chk bound to the design.
`default_nettype none
module tb_bbr_remap;
	timeunit 1ns;
	timeprecision 1ns;
	logic               clk_sys, rst, slow, up_ready, dn_ready;
	bbr_pkg::bbr_req_t  up_req;
	bbr_pkg::bbr_rsp_t  up_rsp, dn_rsp;
	bbr_pkg::bbr_mreq_t dn_req;
	int                 n_mismatch = 0;
	int                 total_checks = 0;
	bbr_remap bbr_remap_inst (.clk_sys, .rst, .up_req, .up_ready, .up_rsp, .dn_req,
		.dn_ready, .dn_rsp);
	bbr_mem bbr_mem_inst (.clk_sys, .rst, .slow, .dn_req, .dn_ready, .dn_rsp);
	initial begin
		clk_sys = 1'h0;
		forever #5 clk_sys = ~clk_sys;
	end
	// ==========
	// Shared tasks
	task automatic chk(input logic [31:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// Entered at a falling edge; request held until the edge that takes it
	task automatic acc(input logic wr, fc, input logic [1:0] sz,
			input logic [31:0] a, wd, output bbr_pkg::bbr_rsp_t r);
		int n;
		up_req = {1'h1, wr, fc, sz, a, wd};
		for (n = 0; up_ready !== 1'h1 && n < 50; n++) @(negedge clk_sys);
		if (n == 50) n_mismatch++;
		@(negedge clk_sys);
		up_req = '0;
		for (n = 0; up_rsp.valid !== 1'h1 && n < 50; n++) @(negedge clk_sys);
		r = up_rsp;
		if (n == 50) n_mismatch++;
	endtask
	// ==========
	// Scenarios
	task automatic t_direct;
		bbr_pkg::bbr_rsp_t r;
		acc(1'h1, 1'h0, 2'h2, 32'h2000_0000, 32'h1234_5678, r);
		acc(1'h1, 1'h0, 2'h2, 32'h2000_0004, 32'h4433_2211, r);
		acc(1'h1, 1'h0, 2'h0, 32'h2000_0007, 32'hEE00_0000, r);
		acc(1'h0, 1'h0, 2'h2, 32'h2000_0004, 32'h0, r);
		chk(r.rdata, 32'hEE33_2211);
	endtask
	task automatic t_alias_rd;
		bbr_pkg::bbr_rsp_t r;
		for (int i = 0; i < 8; i++) begin
			acc(1'h0, 1'h0, 2'h2, 32'h2200_0080 + 32'(i * 4), 32'h0, r);
			chk(r.rdata, 32'((8'h11 >> i) & 8'h01));
		end
	endtask
	task automatic t_alias_wr;
		bbr_pkg::bbr_rsp_t r;
		logic [31:0] v [4] = '{32'h0000_00FE, 32'h0000_0001, 32'hFFFF_FFFF, 32'h0000_000E};
		logic [2:0]  b [4] = '{3'h0, 3'h7, 3'h1, 3'h4};
		for (int i = 0; i < 4; i++) begin
			acc(1'h1, 1'h0, 2'(i % 3), 32'h2200_0080 | {27'h0, b[i], 2'h0}, v[i], r);
		end
		acc(1'h0, 1'h0, 2'h2, 32'h2000_0004, 32'h0, r);
		chk(r.rdata, 32'hEE33_2282);
		acc(1'h1, 1'h0, 2'h2, 32'h4000_0008, 32'h0, r);
		acc(1'h1, 1'h0, 2'h2, 32'h4200_012C, 32'h0000_0001, r);
		acc(1'h0, 1'h0, 2'h2, 32'h4000_0008, 32'h0, r);
		chk(r.rdata, 32'h0000_0800);
		acc(1'h0, 1'h0, 2'h2, 32'h4200_012C, 32'h0, r);
		chk(r.rdata, 32'h0000_0001);
	endtask
	task automatic t_fetch;
		bbr_pkg::bbr_rsp_t r;
		acc(1'h0, 1'h1, 2'h2, 32'h4200_0000, 32'h0, r);
		chk({31'h0, r.error}, 32'h1);
		chk(r.rdata, 32'h0);
		acc(1'h0, 1'h1, 2'h2, 32'h2200_0080, 32'h0, r);
		chk(r.rdata, 32'h1234_5678);
		acc(1'h0, 1'h0, 2'h2, 32'h2208_0000, 32'h0, r);
		chk(r.rdata, 32'h1234_5678);
	endtask
	// Reset in mid-run: no request accepted during it, clean restart after it
	task automatic t_reset;
		bbr_pkg::bbr_rsp_t r;
		rst = 1'h1;
		repeat (2) @(negedge clk_sys);
		chk({31'h0, up_ready}, 32'h0);
		rst = 1'h0;
		acc(1'h0, 1'h0, 2'h2, 32'h2000_0004, 32'h0, r);
		chk(r.rdata, 32'h0);
		acc(1'h0, 1'h0, 2'h2, 32'h2200_0080, 32'h0, r);
		chk(r.rdata, 32'h0);
	endtask
	initial begin
		rst = 1'h1;
		slow = 1'h0;
		up_req = '0;
		repeat (6) @(posedge clk_sys);
		@(negedge clk_sys);
		rst = 1'h0;
		t_direct();
		t_alias_rd();
		slow = 1'h1;
		t_alias_wr();
		slow = 1'h0;
		t_fetch();
		t_reset();
		final_report();
	end
	// Whole run needs well under 2000 cycles
	initial begin
		#100000;
		n_mismatch++;
		final_report();
	end
endmodule // tb_bbr_remap
`default_nettype wire
